// file: rbs_reset_boot.sv
// Purpose: reset distribution, retained registers and boot-source choice
// Assumes: i_clk runs through reset; i_rst_n is the power-on reset
// Notes: fixed 19,200 baud holds only with the 100 MHz system clock
// Overview of operation
// - Pin low resets core, registers and modem together, except kept bits.
// - Pin reset gives modem a general reset, leaving it powersaved.
// - No external memory access from reset until the pin rises.
// - At the rising edge choose external memory or boot ROM.
// - Power-on reset acts like a pin reset except for kept bits.
// - Oscillator control byte cleared at power-on, kept through pin reset.
// - Watchdog timeout flag cleared at power-on, kept through pin reset.
// - Clock control bits, time counter and alarm never reset.
// - Serial data buffer never reset by either reset.
// - Reset with bias low leaves boot ROM; device boots externally.
// - A pulse shorter than 0.4 s always boots from external memory.
// - Boot stub loads a loader over serial into data RAM, runs it.
// - Boot download runs at a fixed 19,200 baud, not configurable.
`timescale 1ns/1ps
module rbs_reset_boot #(
	parameter int unsigned SHORT_CYC = rbs_pkg::SHORT_PULSE_CYC,
	parameter int unsigned LONG_CYC = rbs_pkg::LONG_PULSE_CYC,
	parameter int unsigned BAUD_DIV = rbs_pkg::BAUD_DIV_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ext_reset_low_n,
	input wire logic i_bias_ref_pin,
	input wire rbs_pkg::rbs_wr_t i_wr,
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_flag_clr,
	input wire logic i_rtc_tick,
	input wire logic i_modem_powerup,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic [rbs_pkg::RAM_AW-1:0] i_ram_raddr,
	output logic o_core_rst_n,
	output logic o_modem_reset,
	output logic o_modem_powersave,
	output logic o_ext_mem_en,
	output logic o_boot_rom,
	output logic o_loader_run,
	output logic o_baud_tick,
	output logic [7:0] o_ram_rdata,
	output rbs_pkg::rbs_retained_t o_retained
);
	import rbs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [1:0] sync_w;
	logic pin_high;
	logic bias_high;
	logic pulse_short;
	logic pulse_long;
	logic running;
	rbs_state_t state_reg;
	rbs_state_t state_next;
	rbs_load_t phase_reg;
	logic [LEN_W-1:0] len_reg;
	logic [LEN_W-1:0] cnt_reg;
	logic [BAUD_CNT_W-1:0] baud_reg;
	logic [7:0] onchip_data_ram [0:RAM_DEPTH-1];
	logic load_done;
	logic [7:0] osc_ctrl_reg;
	logic [7:0] watchdog_ctrl_reg;
	logic [7:0] clock_calendar_ctrl_reg;
	logic [31:0] rtc_time_counter_reg;
	logic [31:0] rtc_alarm_value_reg;
	logic [7:0] serial_data_buffer_reg;

	rbs_sync2 u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_bias_ref_pin, i_ext_reset_low_n}),
		.o_sync(sync_w)
	);

	assign pin_high = sync_w[SYNC_PIN];
	assign bias_high = sync_w[SYNC_BIAS];

	rbs_pulse_timer #(
		.SHORT_CYC(SHORT_CYC),
		.LONG_CYC(LONG_CYC)
	) u_timer (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(!pin_high),
		.i_clear(state_reg != ST_RESET),
		.o_short(pulse_short),
		.o_long(pulse_long)
	);

	////////////////////////////////////////////////////////////////////////
	// Boot-source sequencer; power-on reset lands in the same reset state

	assign load_done = (phase_reg == LD_DATA) && (cnt_reg == len_reg);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RESET: begin
				if (pin_high) begin
					// Pulses between thresholds fall back to external boot
					if (!pulse_short && pulse_long && bias_high) begin
						state_next = ST_BOOT_LOAD;
					end else begin
						state_next = ST_RUN_EXT;
					end
				end
			end
			ST_BOOT_LOAD: begin
				if (load_done) begin
					state_next = ST_BOOT_RUN;
				end
			end
			ST_BOOT_RUN: state_next = ST_BOOT_RUN;
			ST_RUN_EXT: state_next = ST_RUN_EXT;
		endcase
		if (!pin_high) begin
			state_next = ST_RESET;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign running = state_reg != ST_RESET;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_core_rst_n <= 1'b0;
			o_modem_reset <= 1'b1;
			o_ext_mem_en <= 1'b0;
			o_boot_rom <= 1'b0;
			o_loader_run <= 1'b0;
		end else begin
			o_core_rst_n <= state_next != ST_RESET;
			o_modem_reset <= state_next == ST_RESET;
			// External bus stays quiet through reset and stub download
			o_ext_mem_en <= (state_next == ST_RUN_EXT) ||
				(state_next == ST_BOOT_RUN);
			o_boot_rom <= (state_next == ST_BOOT_LOAD) ||
				(state_next == ST_BOOT_RUN);
			o_loader_run <= state_next == ST_BOOT_RUN;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_modem_powersave <= 1'b1;
		end else if (!pin_high) begin
			o_modem_powersave <= 1'b1;
		end else if (running && i_modem_powerup) begin
			o_modem_powersave <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fixed download rate; no register can retune it

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			baud_reg <= '0;
			o_baud_tick <= 1'b0;
		end else if (baud_reg == BAUD_CNT_W'(BAUD_DIV - 1)) begin
			baud_reg <= '0;
			o_baud_tick <= 1'b1;
		end else begin
			baud_reg <= baud_reg + 1'b1;
			o_baud_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stub download: length high, length low, then that many bytes

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_reg <= LD_LEN_HI;
			len_reg <= '0;
			cnt_reg <= '0;
		end else if (state_reg != ST_BOOT_LOAD) begin
			phase_reg <= LD_LEN_HI;
			cnt_reg <= '0;
		end else if (i_rx_valid && !load_done) begin
			unique case (phase_reg)
				LD_LEN_HI: begin
					len_reg[15:8] <= i_rx_byte;
					phase_reg <= LD_LEN_LO;
				end
				LD_LEN_LO: begin
					len_reg[7:0] <= i_rx_byte;
					phase_reg <= LD_DATA;
				end
				LD_DATA: cnt_reg <= cnt_reg + 1'b1;
				default: phase_reg <= LD_LEN_HI;
			endcase
		end
	end

	// Loader images larger than the RAM wrap around its address space
	always_ff @(posedge i_clk) begin
		if (state_reg == ST_BOOT_LOAD && i_rx_valid &&
			phase_reg == LD_DATA && !load_done) begin
			onchip_data_ram[cnt_reg[RAM_AW-1:0]] <= i_rx_byte;
		end
		o_ram_rdata <= onchip_data_ram[i_ram_raddr];
	end

	////////////////////////////////////////////////////////////////////////
	// Retained registers; writes only land while the core is running
	assign o_retained = {osc_ctrl_reg, watchdog_ctrl_reg,
		clock_calendar_ctrl_reg, rtc_time_counter_reg,
		rtc_alarm_value_reg, serial_data_buffer_reg};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			osc_ctrl_reg <= OSC_CTRL_RST;
		end else if (running && i_wr.osc_we) begin
			osc_ctrl_reg <= i_wr.wdata[7:0];
		end
	end

	// Other watchdog bits live in the watchdog block and read as zero here
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			watchdog_ctrl_reg <= 8'h00;
		end else if (i_wdt_timeout) begin
			watchdog_ctrl_reg[WDT_FLAG_BIT] <= 1'b1;
		end else if (running && i_wdt_flag_clr) begin
			watchdog_ctrl_reg[WDT_FLAG_BIT] <= 1'b0;
		end
	end

	// No reset at all: the real-time clock keeps counting through reset
	always_ff @(posedge i_clk) begin
		if (running && i_wr.rtc_ctrl_we) begin
			clock_calendar_ctrl_reg <=
				i_wr.wdata[7:0] & RTC_CTRL_KEEP;
		end
		if (running && i_wr.time_we) begin
			rtc_time_counter_reg <= i_wr.wdata;
		end else if (clock_calendar_ctrl_reg[RTC_RUN_BIT] &&
			i_rtc_tick) begin
			rtc_time_counter_reg <=
				rtc_time_counter_reg + 32'h1;
		end
		if (running && i_wr.alarm_we) begin
			rtc_alarm_value_reg <= i_wr.wdata;
		end
		if (running && i_wr.serbuf_we) begin
			serial_data_buffer_reg <= i_wr.wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_core_rst;
		@(posedge i_clk) disable iff (!i_rst_n)
		!pin_high |=> !o_core_rst_n && o_modem_reset;
	endproperty
	a_core_rst: assert property (p_core_rst)
		else $error("core not held in reset while pin low");

	property p_powersave;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_modem_reset) |-> o_modem_powersave;
	endproperty
	a_powersave: assert property (p_powersave)
		else $error("modem not powersaved after reset");

	property p_no_ext;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!o_core_rst_n || state_reg == ST_BOOT_LOAD) |-> !o_ext_mem_en;
	endproperty
	a_no_ext: assert property (p_no_ext)
		else $error("external memory enabled during reset");

	property p_boot_pick;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_reg == ST_RESET && pin_high && pulse_long && bias_high)
		|=> o_boot_rom && !o_ext_mem_en;
	endproperty
	a_boot_pick: assert property (p_boot_pick)
		else $error("long pulse with bias high did not pick boot ROM");

	property p_short_ext;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_reg == ST_RESET && pin_high && pulse_short)
		|=> o_ext_mem_en && !o_boot_rom;
	endproperty
	a_short_ext: assert property (p_short_ext)
		else $error("short pulse did not boot externally");

	property p_osc_keep;
		@(posedge i_clk) disable iff (!i_rst_n)
		!running |=> $stable(o_retained.osc_ctrl_reg);
	endproperty
	a_osc_keep: assert property (p_osc_keep)
		else $error("oscillator control changed in pin reset");

	property p_wdt_flag;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_wdt_timeout || (!running && watchdog_ctrl_reg[WDT_FLAG_BIT]))
		|=> watchdog_ctrl_reg[WDT_FLAG_BIT];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag)
		else $error("watchdog flag lost before core restarted");

	property p_time_run;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_retained.clock_calendar_ctrl[RTC_RUN_BIT] && i_rtc_tick &&
			!running) |=> o_retained.rtc_time_counter ==
			$past(o_retained.rtc_time_counter) + 32'h1;
	endproperty
	a_time_run: assert property (p_time_run)
		else $error("time counter stopped during reset");

	property p_serbuf_keep;
		@(posedge i_clk) disable iff (!i_rst_n)
		!running |=> $stable(o_retained.serial_data_buffer);
	endproperty
	a_serbuf_keep: assert property (p_serbuf_keep)
		else $error("serial buffer changed during reset");

	property p_load_done;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_reg == ST_BOOT_LOAD && load_done && pin_high)
		|=> o_loader_run && o_ext_mem_en;
	endproperty
	a_load_done: assert property (p_load_done)
		else $error("loader not started after download");
endmodule : rbs_reset_boot

// file: rbs_pkg.sv
// Purpose: shared constants, states and carriers of the reset/boot block
// Assumes: one free-running 100 MHz clock
// Notes: all timing counts derive from the printed times and the clock rate
package rbs_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

	// Reset pulse length thresholds in milliseconds
	localparam int unsigned SHORT_PULSE_MS = 400;
	localparam int unsigned LONG_PULSE_MS = 2000;
	localparam int unsigned SHORT_PULSE_CYC = CLK_KHZ * SHORT_PULSE_MS;
	localparam int unsigned LONG_PULSE_CYC = CLK_KHZ * LONG_PULSE_MS;
	localparam int unsigned PULSE_CNT_W = 28;

	// Fixed download rate of the boot stub
	localparam int unsigned BOOT_BAUD = 19_200;
	localparam int unsigned BAUD_DIV_CYC = CLK_HZ / BOOT_BAUD;
	localparam int unsigned BAUD_CNT_W = 13;

	// On-chip data RAM used for the second-stage loader
	localparam int unsigned RAM_AW = 12;
	localparam int unsigned RAM_DEPTH = 1 << RAM_AW;
	localparam int unsigned LEN_W = 16;

	// Retained bit positions
	localparam int unsigned WDT_FLAG_BIT = 2;
	localparam int unsigned RTC_RUN_BIT = 7;
	localparam int unsigned RTC_AUX_BIT = 3;
	localparam logic [7:0] OSC_CTRL_RST = 8'h00;
	localparam logic [7:0] RTC_CTRL_KEEP = 8'h88;

	// Synchroniser lanes
	localparam int unsigned SYNC_PIN = 0;
	localparam int unsigned SYNC_BIAS = 1;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_BOOT_LOAD = 2'b01,
		ST_BOOT_RUN = 2'b11,
		ST_RUN_EXT = 2'b10
	} rbs_state_t;

	typedef enum logic [1:0] {
		LD_LEN_HI = 2'b00,
		LD_LEN_LO = 2'b01,
		LD_DATA = 2'b11
	} rbs_load_t;

	typedef struct packed {
		logic [7:0] osc_ctrl_reg;
		logic [7:0] watchdog_ctrl_reg;
		logic [7:0] clock_calendar_ctrl;
		logic [31:0] rtc_time_counter;
		logic [31:0] rtc_alarm_value;
		logic [7:0] serial_data_buffer;
	} rbs_retained_t;

	typedef struct packed {
		logic osc_we;
		logic rtc_ctrl_we;
		logic time_we;
		logic alarm_we;
		logic serbuf_we;
		logic [31:0] wdata;
	} rbs_wr_t;
endpackage : rbs_pkg

// file: rbs_sync2.sv
// Purpose: two-flop synchroniser for the reset pin and bias comparator
// Assumes: inputs are asynchronous to i_clk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module rbs_sync2 (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [1:0] i_async,
	output logic [1:0] o_sync
);
	import rbs_pkg::*;

	logic [1:0] meta_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 2'h0;
			o_sync <= 2'h0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule : rbs_sync2

// file: rbs_pulse_timer.sv
// Purpose: measures the length of the reset pin low pulse
// Assumes: i_run is the synchronised pin-low level
// Notes: counter saturates, so very long pulses stay classified as long
`timescale 1ns/1ps
module rbs_pulse_timer #(
	parameter int unsigned SHORT_CYC = rbs_pkg::SHORT_PULSE_CYC,
	parameter int unsigned LONG_CYC = rbs_pkg::LONG_PULSE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic i_clear,
	output logic o_short,
	output logic o_long
);
	import rbs_pkg::*;

	logic [PULSE_CNT_W-1:0] cnt_reg;
	localparam logic [PULSE_CNT_W-1:0] CNT_MAX = '1;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
		end else if (i_run) begin
			if (cnt_reg != CNT_MAX) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end else if (i_clear) begin
			cnt_reg <= '0;
		end
	end

	assign o_short = cnt_reg < PULSE_CNT_W'(SHORT_CYC);
	assign o_long = cnt_reg >= PULSE_CNT_W'(LONG_CYC);
endmodule : rbs_pulse_timer

// file: rbs_board_model.sv
// Purpose: board reset source and boot jumper facing the reset/boot block
// Assumes: driven from the falling edge, like the rest of the bench
// Notes: bias reads low when the jumper is out, as the pin is pulled down
`timescale 1ns/1ps
module rbs_board_model #(
	parameter int unsigned BIAS_HOLD = 100
) (
	input wire logic i_clk,
	input wire logic i_start,
	input wire logic [15:0] i_len,
	input wire logic i_jumper,
	output logic o_ext_reset_low_n,
	output logic o_bias_ref_pin
);
	logic [15:0] low_cnt = 16'h0000;
	logic [7:0] hold_cnt = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Pin held low for the commanded number of cycles
	always @(negedge i_clk) begin
		if (i_start) begin
			low_cnt <= i_len;
		end else if (low_cnt != 16'h0000) begin
			low_cnt <= low_cnt - 16'h0001;
		end
	end

	// Jumper stays on at least 1 us past the rising pin
	always @(negedge i_clk) begin
		if (low_cnt == 16'h0001) begin
			hold_cnt <= BIAS_HOLD[7:0];
		end else if (hold_cnt != 8'h00) begin
			hold_cnt <= hold_cnt - 8'h01;
		end
	end

	assign o_ext_reset_low_n = (low_cnt == 16'h0000);
	assign o_bias_ref_pin = i_jumper &
		((low_cnt != 16'h0000) | (hold_cnt != 8'h00));
endmodule : rbs_board_model

// file: testbench.sv
// Purpose: self-checking bench of the reset/boot block
// Assumes: short pulse 40, long pulse 200, baud divider 8 cycles
// Notes: pulses of 10, 100 and 250 cycles sit clear of both thresholds
`timescale 1ns/1ps
module testbench;
	import rbs_pkg::*;
	logic clk, rst_n, start, jumper, wdt_to, wdt_clr, tick, pup, rxv;
	logic [15:0] len;
	logic [7:0] rxb, rdata;
	logic [11:0] raddr;
	rbs_wr_t wr_s;
	rbs_retained_t ret;
	logic pin_n, bias, core_n, mrst, psave, xmem, brom, lrun, btick;
	int miscompares = 0;
	int total_checks = 0;

	always #5 clk = ~clk;

	rbs_board_model i_rbs_board_model (.i_clk(clk), .i_start(start),
		.i_len(len), .i_jumper(jumper), .o_ext_reset_low_n(pin_n),
		.o_bias_ref_pin(bias));
	rbs_reset_boot #(.SHORT_CYC(40), .LONG_CYC(200), .BAUD_DIV(8))
	i_rbs_reset_boot (.i_clk(clk), .i_rst_n(rst_n),
		.i_ext_reset_low_n(pin_n), .i_bias_ref_pin(bias), .i_wr(wr_s),
		.i_wdt_timeout(wdt_to), .i_wdt_flag_clr(wdt_clr), .i_rtc_tick(tick),
		.i_modem_powerup(pup), .i_rx_valid(rxv), .i_rx_byte(rxb),
		.i_ram_raddr(raddr), .o_core_rst_n(core_n), .o_modem_reset(mrst),
		.o_modem_powersave(psave), .o_ext_mem_en(xmem), .o_boot_rom(brom),
		.o_loader_run(lrun), .o_baud_tick(btick), .o_ram_rdata(rdata),
		.o_retained(ret));

	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task lim_out(input logic [31:0] got, input logic [31:0] exp);
		miscompares++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		give_verdict;
	endtask : lim_out

	task wait_core(input logic lvl, input int lim);
		int n;
		n = 0;
		while (core_n !== lvl) begin
			if (n == lim) begin
				lim_out(core_n, lvl);
			end
			@(negedge clk);
			n++;
		end
	endtask : wait_core

	task pulse(input logic [15:0] n, input logic j);
		@(negedge clk);
		jumper <= j;
		start <= 1'b1;
		len <= n;
		@(negedge clk);
		start <= 1'b0;
		wait_core(1'b0, 10);
	endtask : pulse

	task release_chk(input logic rom);
		wait_core(1'b1, 400);
		chk(brom, rom);
		chk(xmem, !rom);
		chk(mrst, 1'b0);
		chk(lrun, 1'b0);
	endtask : release_chk

	task wr(input logic [4:0] we, input logic [31:0] d);
		@(negedge clk);
		wr_s <= rbs_wr_t'({we, d});
		@(negedge clk);
		wr_s <= '0;
	endtask : wr

	task send_byte(input logic [7:0] b);
		@(negedge clk);
		rxv <= 1'b1;
		rxb <= b;
		@(negedge clk);
		rxv <= 1'b0;
	endtask : send_byte

	////////////////////////////////////////////////////////////////////////
	task t_por;
		release_chk(1'b0);
		chk(ret.osc_ctrl_reg, 8'h00);
		chk(ret.watchdog_ctrl_reg[WDT_FLAG_BIT], 1'b0);
		chk(psave, 1'b1);
		$display("test por done");
	endtask : t_por

	task t_pin_keep;
		wr(5'h1F, 32'h1234_56A5);
		@(negedge clk) wdt_to <= 1'b1;
		@(negedge clk) {wdt_to, wdt_clr} <= 2'b01;
		@(negedge clk) {wdt_to, wdt_clr} <= 2'b11;
		chk(ret.watchdog_ctrl_reg[WDT_FLAG_BIT], 1'b0);
		@(negedge clk) {wdt_to, wdt_clr} <= 2'b00;
		@(negedge clk) pup <= 1'b1;
		@(negedge clk) pup <= 1'b0;
		@(negedge clk);
		chk(psave, 1'b0);
		pulse(16'd10, 1'b1);
		chk(mrst, 1'b1);
		chk(psave, 1'b1);
		chk(xmem, 1'b0);
		chk(brom, 1'b0);
		tick <= 1'b1;
		@(negedge clk) tick <= 1'b0;
		// Writes while the core is held must be dropped
		wr(5'h1F, 32'h0F0F_0F0F);
		release_chk(1'b0);
		chk(ret.osc_ctrl_reg, 8'hA5);
		chk(ret.watchdog_ctrl_reg[WDT_FLAG_BIT], 1'b1);
		chk(ret.clock_calendar_ctrl, 8'h80);
		chk(ret.rtc_time_counter, 32'h1234_56A6);
		chk(ret.rtc_alarm_value, 32'h1234_56A5);
		chk(ret.serial_data_buffer, 8'hA5);
		$display("test pin reset keep done");
	endtask : t_pin_keep

	task t_boot_rom;
		int n;
		pulse(16'd250, 1'b1);
		release_chk(1'b1);
		n = 0;
		while (btick !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (btick !== 1'b1) begin
			lim_out(btick, 1'b1);
		end
		@(negedge clk);
		n = 1;
		while (btick !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (btick !== 1'b1) begin
			lim_out(btick, 1'b1);
		end
		chk(n, 8);
		send_byte(8'h00);
		send_byte(8'h02);
		send_byte(8'h3C);
		send_byte(8'hC3);
		n = 0;
		while (lrun !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		if (lrun !== 1'b1) begin
			lim_out(lrun, 1'b1);
		end
		chk(lrun, 1'b1);
		chk(xmem, 1'b1);
		raddr <= 12'h000;
		@(negedge clk);
		chk(rdata, 8'h3C);
		raddr <= 12'h001;
		@(negedge clk);
		chk(rdata, 8'hC3);
		$display("test boot rom done");
	endtask : t_boot_rom

	task t_leave_boot;
		pulse(16'd250, 1'b0);
		release_chk(1'b0);
		pulse(16'd100, 1'b1);
		release_chk(1'b0);
		$display("test leave boot done");
	endtask : t_leave_boot

	task t_por_again;
		@(negedge clk) rst_n <= 1'b0;
		@(negedge clk);
		chk(core_n, 1'b0);
		chk(ret.osc_ctrl_reg, 8'h00);
		chk(ret.watchdog_ctrl_reg[WDT_FLAG_BIT], 1'b0);
		chk(ret.rtc_time_counter, 32'h1234_56A6);
		chk(ret.serial_data_buffer, 8'hA5);
		rst_n <= 1'b1;
		release_chk(1'b0);
		$display("test power-on again done");
	endtask : t_por_again

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{start, jumper, wdt_to, wdt_clr, tick, pup, rxv} = 7'h00;
		len = 16'h0000;
		rxb = 8'h00;
		raddr = 12'h000;
		wr_s = '0;
		repeat (20) @(negedge clk);
		rst_n <= 1'b1;
		t_por();
		t_pin_keep();
		t_boot_rom();
		t_leave_boot();
		t_por_again();
		give_verdict();
	end
endmodule : testbench
